// [common/clock_select_time_base_pkg.sv]
// Purpose: Shared constants and types for the clock select and time base block
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one register per word
// Notes: Register indices are word indices; byte address is four times the index
package clock_select_time_base_pkg;

   // ----------------------------------------
   // Clocking
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 50_000_000;

   // ----------------------------------------
   // Time base chain layout
   // ----------------------------------------
   localparam int unsigned TBC_WIDTH = 15;
   localparam logic [14:0] TBC_RST = 15'h0000;
   localparam int unsigned STG_256HZ = 6;
   localparam int unsigned STG_128HZ = 7;
   localparam int unsigned STG_64HZ = 8;
   localparam int unsigned STG_32HZ = 9;
   localparam int unsigned STG_16HZ = 10;
   localparam int unsigned STG_8HZ = 11;
   localparam int unsigned STG_1HZ = 14;
   localparam logic [14:0] TBC_LOW_RATE_KEEP = 15'h07ff;
   localparam logic [3:0] DECADE_RST = 4'h0;
   localparam logic [3:0] DECADE_LAST = 4'h9;
   localparam logic [3:0] DECADE_HIGH_FROM = 4'h5;

   // ----------------------------------------
   // Tick taps (order of event vector)
   // ----------------------------------------
   localparam int unsigned TICK_COUNT = 5;
   localparam int unsigned TICK_256HZ = 0;
   localparam int unsigned TICK_32HZ = 1;
   localparam int unsigned TICK_16HZ = 2;
   localparam int unsigned TICK_1HZ = 3;
   localparam int unsigned TICK_0P1HZ = 4;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [5:0] IDX_CLOCK_SOURCE_SELECT = 6'h09;
   localparam logic [5:0] IDX_TIME_BASE_READOUT = 6'h0f;
   localparam logic [5:0] IDX_DECADE_TICK_REQUEST = 6'h33;
   localparam logic [5:0] IDX_TICK_REQUEST = 6'h35;
   localparam logic [7:0] ADDR_CLOCK_SOURCE_SELECT = {IDX_CLOCK_SOURCE_SELECT, 2'b00};
   localparam logic [7:0] ADDR_TIME_BASE_READOUT = {IDX_TIME_BASE_READOUT, 2'b00};
   localparam logic [7:0] ADDR_DECADE_TICK_REQUEST = {IDX_DECADE_TICK_REQUEST, 2'b00};
   localparam logic [7:0] ADDR_TICK_REQUEST = {IDX_TICK_REQUEST, 2'b00};

   // ----------------------------------------
   // Fields and reset values
   // ----------------------------------------
   localparam int unsigned FAST_CLOCK_PICK_BIT = 0;
   localparam int unsigned RC_ACTIVE_BIT = 1;
   localparam logic FAST_CLOCK_PICK_RST = 1'b0;
   localparam logic [3:0] TICK_REQUEST_RST = 4'h0;
   localparam logic DECADE_REQUEST_RST = 1'b0;

   // ----------------------------------------
   // Clock switch states
   // ----------------------------------------
   typedef enum logic [3:0] {
      SW_XTAL = 4'b0001,
      SW_TO_RC = 4'b0010,
      SW_RC = 4'b0100,
      SW_TO_XTAL = 4'b1000
   } switch_state_type;

endpackage

// [rtl/clock_select_time_base.sv]
// Purpose: Clock source selection and time base divider chain with register access
// Assumes: Oscillator levels arrive synchronous to i_clk; Avalon-MM slave, 32-bit
// Notes: Chain advances on falling edges of the sampled crystal level
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ns

// Notes on behaviour
// - Select bit 0 clear picks crystal clock, set picks RC clock.
// - RC oscillator runs when picked, while the switch is still on it, or in test fast-clock output mode.
// - Crystal oscillator always runs, even while RC clock drives the system.
// - Reset clears the select bit, so the crystal clock drives the system.
// - Setting the select bit raises the internal logic supply at the same time.
// - Fifteen binary stages plus a divide-by-ten stage, all from the crystal.
// - Chain starts at zero after reset and steps on crystal falling edges.
// - Falling edges of 256, 32, 16, 1 and 0.1 Hz raise tick requests.
// - The 16 Hz stage feeds the watchdog count input.
// - The 1, 8 and 16 Hz stages feed the buzzer driver.
// - The 64 Hz stage is the input port sampling clock.
// - The 1 and 8 Hz stages feed the system reset circuit.
// - The 256, 128, 64 and 32 Hz stages are capture input data.
// - Readout returns 8, 4, 2, 1 Hz stage levels in bits 0 to 3.
// - Any readout write clears 8, 4, 2, 1 and 0.1 Hz stages; data ignored.
// - A write that drops a high stage raises that stage's tick request.
// - Requests for 256, 32, 16, 1 Hz sit in bits 0 to 3 of one register.
module clock_select_time_base
   import clock_select_time_base_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Oscillator levels
   input wire logic i_xtal_clk,
   input wire logic i_rc_clk,
   // Test mode
   input wire logic i_test_fast_clk_out,
   // Avalon-MM slave
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Clock control
   output logic o_sys_clk,
   output logic o_rc_osc_enable,
   output logic o_xtal_osc_enable,
   output logic o_logic_supply_raise,
   // Time base taps
   output logic o_wdt_tick,
   output logic [2:0] o_buzzer_ticks,
   output logic o_port_sample_clk,
   output logic [1:0] o_reset_ticks,
   output logic [3:0] o_capture_data,
   // Tick events and requests
   output logic [4:0] o_tick_events,
   output logic [3:0] o_tick_request,
   output logic o_decade_tick_request
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic xtal_q;
   logic xtal_prev_q;
   logic rc_q;
   logic rc_prev_q;
   logic xtal_fall;
   logic fast_clock_pick_q;
   logic rc_active;
   logic [14:0] time_base_divider_q;
   logic [14:0] time_base_divider_d;
   logic decade_level;
   logic one_hz_fall;
   logic [4:0] tick_now;
   logic [4:0] tick_prev_q;
   logic [4:0] tick_fall;
   logic [3:0] tick_request_q;
   logic decade_request_q;
   logic [31:0] readdata_q;
   logic ack_q;
   logic req;
   logic wr_take;
   logic wr_lane0;
   logic hit_select;
   logic hit_readout;
   logic hit_request;
   logic hit_decade;
   logic [31:0] read_mux;

   // ----------------------------------------
   // Oscillator sampling
   // ----------------------------------------

   // Keep current and previous levels for edge detection
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         xtal_q <= 1'b0;
         xtal_prev_q <= 1'b0;
         rc_q <= 1'b0;
         rc_prev_q <= 1'b0;
      end else begin
         xtal_q <= i_xtal_clk;
         xtal_prev_q <= xtal_q;
         rc_q <= i_rc_clk;
         rc_prev_q <= rc_q;
      end
   end

   assign xtal_fall = xtal_prev_q & ~xtal_q;

   // ----------------------------------------
   // Bus handshake
   // ----------------------------------------

   // One wait state: data is prepared, then the request completes
   assign req = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = req & ~ack_q;
   assign wr_take = i_avs_write & ack_q;
   assign wr_lane0 = wr_take & i_avs_byteenable[0];

   // Acknowledge one cycle after a request appears
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   // Address decode
   always_comb begin
      hit_select = 1'b0;
      hit_readout = 1'b0;
      hit_request = 1'b0;
      hit_decade = 1'b0;
      if (i_avs_address == ADDR_CLOCK_SOURCE_SELECT) begin
         hit_select = 1'b1;
      end else if (i_avs_address == ADDR_TIME_BASE_READOUT) begin
         hit_readout = 1'b1;
      end else if (i_avs_address == ADDR_TICK_REQUEST) begin
         hit_request = 1'b1;
      end else if (i_avs_address == ADDR_DECADE_TICK_REQUEST) begin
         hit_decade = 1'b1;
      end
   end

   // ----------------------------------------
   // Clock source select
   // ----------------------------------------

   // Select bit, cleared by reset
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         fast_clock_pick_q <= FAST_CLOCK_PICK_RST;
      end else if (wr_lane0 && hit_select) begin
         fast_clock_pick_q <= i_avs_writedata[FAST_CLOCK_PICK_BIT];
      end
   end

   clock_switch clock_switch_inst (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_xtal_now(xtal_q),
      .i_xtal_prev(xtal_prev_q),
      .i_rc_now(rc_q),
      .i_rc_prev(rc_prev_q),
      .i_pick_rc(fast_clock_pick_q),
      .o_sys_clk(o_sys_clk),
      .o_rc_active(rc_active)
   );

   // Oscillator enables and supply control; RC runs until the switch has left it
   assign o_rc_osc_enable = fast_clock_pick_q | rc_active | i_test_fast_clk_out;
   assign o_xtal_osc_enable = 1'b1;
   assign o_logic_supply_raise = fast_clock_pick_q;

   // ----------------------------------------
   // Time base chain
   // ----------------------------------------

   // Next count: step on crystal fall, then low-rate stages cleared on write
   always_comb begin
      time_base_divider_d = time_base_divider_q;
      if (xtal_fall) begin
         time_base_divider_d = time_base_divider_q + 15'h0001;
      end
      if (wr_take && hit_readout) begin
         time_base_divider_d = time_base_divider_d & TBC_LOW_RATE_KEEP;
      end
   end

   // Binary stages
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         time_base_divider_q <= TBC_RST;
      end else begin
         time_base_divider_q <= time_base_divider_d;
      end
   end

   // 1 Hz falls when its stage drops from the carry, not from a clear
   assign one_hz_fall = xtal_fall & (&time_base_divider_q) & ~(wr_take & hit_readout);

   decade_divider decade_divider_inst (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_step(one_hz_fall),
      .i_clear(wr_take & hit_readout),
      .o_level(decade_level)
   );

   // ----------------------------------------
   // Taps to peripherals
   // ----------------------------------------
   assign o_wdt_tick = time_base_divider_q[STG_16HZ];
   assign o_buzzer_ticks = {time_base_divider_q[STG_1HZ],
                            time_base_divider_q[STG_8HZ],
                            time_base_divider_q[STG_16HZ]};
   assign o_port_sample_clk = time_base_divider_q[STG_64HZ];
   assign o_reset_ticks = {time_base_divider_q[STG_1HZ],
                           time_base_divider_q[STG_8HZ]};
   assign o_capture_data = time_base_divider_q[STG_32HZ:STG_256HZ + 0] == 4'h0 ?
                           4'h0 : {time_base_divider_q[STG_32HZ],
                                   time_base_divider_q[STG_64HZ],
                                   time_base_divider_q[STG_128HZ],
                                   time_base_divider_q[STG_256HZ]};

   // ----------------------------------------
   // Tick edge detection
   // ----------------------------------------

   // Current tick levels in event order
   assign tick_now = {decade_level,
                      time_base_divider_q[STG_1HZ],
                      time_base_divider_q[STG_16HZ],
                      time_base_divider_q[STG_32HZ],
                      time_base_divider_q[STG_256HZ]};

   // Previous levels for falling detection
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         tick_prev_q <= 5'h00;
      end else begin
         tick_prev_q <= tick_now;
      end
   end

   // Falling edge per tick, cleared stages included
   genvar g;
   generate
      for (g = 0; g < TICK_COUNT; g++) begin : g_tick
         assign tick_fall[g] = tick_prev_q[g] & ~tick_now[g];
      end
   endgenerate

   // Registered event pulses
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_tick_events <= 5'h00;
      end else begin
         o_tick_events <= tick_fall;
      end
   end

   // ----------------------------------------
   // Tick request flags
   // ----------------------------------------

   // Software may write either value; a new fall always wins
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         tick_request_q <= TICK_REQUEST_RST;
      end else if (wr_lane0 && hit_request) begin
         tick_request_q <= i_avs_writedata[3:0] | tick_fall[TICK_1HZ:TICK_256HZ];
      end else begin
         tick_request_q <= tick_request_q | tick_fall[TICK_1HZ:TICK_256HZ];
      end
   end

   // 0.1 Hz request flag
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         decade_request_q <= DECADE_REQUEST_RST;
      end else if (wr_lane0 && hit_decade) begin
         decade_request_q <= i_avs_writedata[0] | tick_fall[TICK_0P1HZ];
      end else begin
         decade_request_q <= decade_request_q | tick_fall[TICK_0P1HZ];
      end
   end

   assign o_tick_request = tick_request_q;
   assign o_decade_tick_request = decade_request_q;

   // ----------------------------------------
   // Read path
   // ----------------------------------------

   // Read value of the addressed register, zero elsewhere
   always_comb begin
      read_mux = 32'h0000_0000;
      if (hit_select) begin
         read_mux[FAST_CLOCK_PICK_BIT] = fast_clock_pick_q;
         read_mux[RC_ACTIVE_BIT] = rc_active;
      end else if (hit_readout) begin
         read_mux[3:0] = time_base_divider_q[STG_1HZ:STG_8HZ];
      end else if (hit_request) begin
         read_mux[3:0] = tick_request_q;
      end else if (hit_decade) begin
         read_mux[0] = decade_request_q;
      end
   end

   // Capture read data in the wait cycle
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         readdata_q <= 32'h0000_0000;
      end else if (i_avs_read && !ack_q) begin
         readdata_q <= read_mux;
      end
   end

   assign o_avs_readdata = readdata_q;

endmodule // clock_select_time_base

// [rtl/clock_switch.sv]
// Purpose: Glitch-free change of system clock between crystal and RC levels
// Assumes: Both oscillator levels are sampled at i_clk by the caller
// Notes: Output is held low between the old source's fall and the new one's fall
`timescale 1ns/1ns
module clock_switch
   import clock_select_time_base_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Oscillator levels, current and one cycle back
   input wire logic i_xtal_now,
   input wire logic i_xtal_prev,
   input wire logic i_rc_now,
   input wire logic i_rc_prev,
   // Selection
   input wire logic i_pick_rc,
   // Result
   output logic o_sys_clk,
   output logic o_rc_active
);

   switch_state_type state_q;
   logic xtal_fall;
   logic rc_fall;

   assign xtal_fall = i_xtal_prev & ~i_xtal_now;
   assign rc_fall = i_rc_prev & ~i_rc_now;

   // Hand over only at falling edges of both sources
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         state_q <= SW_XTAL;
      end else begin
         case (state_q)
            SW_XTAL: begin
               if (i_pick_rc && xtal_fall) begin
                  state_q <= SW_TO_RC;
               end
            end
            SW_TO_RC: begin
               if (!i_pick_rc) begin
                  state_q <= SW_TO_XTAL;
               end else if (rc_fall) begin
                  state_q <= SW_RC;
               end
            end
            SW_RC: begin
               if (!i_pick_rc && rc_fall) begin
                  state_q <= SW_TO_XTAL;
               end
            end
            SW_TO_XTAL: begin
               if (xtal_fall) begin
                  state_q <= SW_XTAL;
               end
            end
            default: begin
               state_q <= SW_XTAL;
            end
         endcase
      end
   end

   // Registered clock follows the engaged source, low while changing
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_sys_clk <= 1'b0;
         o_rc_active <= 1'b0;
      end else begin
         o_rc_active <= (state_q == SW_RC);
         case (state_q)
            SW_XTAL: o_sys_clk <= i_xtal_now;
            SW_RC: o_sys_clk <= i_rc_now;
            default: o_sys_clk <= 1'b0;
         endcase
      end
   end

endmodule // clock_switch

// [rtl/decade_divider.sv]
// Purpose: Divide-by-ten stage fed by the 1 Hz stage, gives the 0.1 Hz level
// Assumes: i_step is a one-cycle pulse on each falling edge of the 1 Hz stage
// Notes: Clearing while the output is high makes it fall at once
`timescale 1ns/1ns
module decade_divider
   import clock_select_time_base_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Control
   input wire logic i_step,
   input wire logic i_clear,
   // Result
   output logic o_level
);

   logic [3:0] count_q;

   // Count 0..9, clear wins over a step
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         count_q <= DECADE_RST;
      end else if (i_clear) begin
         count_q <= DECADE_RST;
      end else if (i_step) begin
         if (count_q == DECADE_LAST) begin
            count_q <= DECADE_RST;
         end else begin
            count_q <= count_q + 4'h1;
         end
      end
   end

   // High for the second half of the ten-count period
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_level <= 1'b0;
      end else if (i_clear) begin
         o_level <= 1'b0;
      end else if (i_step) begin
         o_level <= (count_q >= (DECADE_HIGH_FROM - 4'h1)) && (count_q != DECADE_LAST);
      end
   end

endmodule // decade_divider

// [test/clock_select_time_base_assertions.sv]
// Purpose: Concurrent checks on the clock select and time base ports
// Assumes: The bus master holds each request until waitrequest is low
// Notes: Bound to the top module and sees its ports only
`timescale 1ns/1ns
module clock_select_time_base_assertions
   import clock_select_time_base_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Inputs watched
   input wire logic i_test_fast_clk_out,
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   // Outputs watched
   input wire logic o_avs_waitrequest,
   input wire logic o_sys_clk,
   input wire logic o_rc_osc_enable,
   input wire logic o_xtal_osc_enable,
   input wire logic o_logic_supply_raise,
   input wire logic o_wdt_tick,
   input wire logic [2:0] o_buzzer_ticks,
   input wire logic [1:0] o_reset_ticks,
   input wire logic [3:0] o_capture_data,
   input wire logic [4:0] o_tick_events,
   input wire logic [3:0] o_tick_request
);
   // ----------------------------------------
   // Completed writes
   // ----------------------------------------
   wire logic wr_ok = i_avs_write && !o_avs_waitrequest;
   wire logic sel_wr = wr_ok && i_avs_byteenable[0] &&
      (i_avs_address == ADDR_CLOCK_SOURCE_SELECT);
   wire logic tb_wr = wr_ok && (i_avs_address == ADDR_TIME_BASE_READOUT);

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   a_xtal_always_on: assert property (o_xtal_osc_enable)
      else $error("crystal enable dropped");
   a_rc_enable_cause: assert property (
      (o_logic_supply_raise || i_test_fast_clk_out) |-> o_rc_osc_enable)
      else $error("rc enable wrong");
   // Bound allows the RC source a few cycles to fall before it is released
   a_rc_stop_bound: assert property (
      $fell(o_logic_supply_raise) && !i_test_fast_clk_out |-> ##[1:16] !o_rc_osc_enable)
      else $error("rc oscillator kept running");
   a_reset_slow_pick: assert property ($rose(i_nrst) |-> !o_logic_supply_raise)
      else $error("select not cleared by reset");
   a_pick_sets_supply: assert property (
      sel_wr |=> o_logic_supply_raise == $past(i_avs_writedata[0]))
      else $error("supply raise not following select");
   a_one_wait_state: assert property (
      (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("waitrequest held too long");
   a_tap_sharing: assert property (
      o_wdt_tick == o_buzzer_ticks[0] && o_reset_ticks == o_buzzer_ticks[2:1])
      else $error("stage taps disagree");
   a_tick_sets_request: assert property (
      |o_tick_events[3:0] |-> (o_tick_request & o_tick_events[3:0]) == o_tick_events[3:0])
      else $error("tick did not set request");
   a_fast_fall_event: assert property (
      $fell(o_capture_data[0]) |->
      ($past(o_tick_events[0]) || o_tick_events[0]) or ##1 o_tick_events[0])
      else $error("256 Hz fall without event");
   a_tick_pulse_short: assert property (o_tick_events[0] |=> !o_tick_events[0])
      else $error("tick event longer than a cycle");
   a_readout_clear: assert property (tb_wr |-> ##[1:2] (o_reset_ticks == 2'b00))
      else $error("readout write did not clear stages");
   a_clk_high_phase: assert property ($rose(o_sys_clk) |=> o_sys_clk)
      else $error("short high system clock phase");
   a_clk_low_phase: assert property ($fell(o_sys_clk) |=> !o_sys_clk)
      else $error("short low system clock phase");
endmodule // clock_select_time_base_assertions

bind clock_select_time_base clock_select_time_base_assertions clock_select_time_base_assertions_inst (
   .i_clk, .i_nrst, .i_test_fast_clk_out, .i_avs_address, .i_avs_read, .i_avs_write,
   .i_avs_writedata, .i_avs_byteenable, .o_avs_waitrequest, .o_sys_clk, .o_rc_osc_enable,
   .o_xtal_osc_enable, .o_logic_supply_raise, .o_wdt_tick, .o_buzzer_ticks, .o_reset_ticks,
   .o_capture_data, .o_tick_events, .o_tick_request);

// [test/clock_select_time_base_tb.sv]
// Purpose: Register level tests of clock selection and the time base chain
// Assumes: Crystal runs at a fast stand-in rate so the 1 Hz stage is reached
// Notes: Bus reads and writes wait on waitrequest, bounded by a watchdog
`timescale 1ns/1ns
module clock_select_time_base_tb;
   import clock_select_time_base_pkg::*;
   localparam int RC_HALF = 3;
   localparam int XT_HALF = 2;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic i_xtal_clk, i_rc_clk;
   logic i_test_fast_clk_out = 1'b0;
   logic [7:0] i_avs_address = 8'h00;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic [3:0] i_avs_byteenable = 4'hf;
   logic [31:0] o_avs_readdata;
   logic o_avs_waitrequest, o_sys_clk, o_rc_osc_enable, o_xtal_osc_enable;
   logic o_logic_supply_raise, o_wdt_tick, o_port_sample_clk, o_decade_tick_request;
   logic [2:0] o_buzzer_ticks;
   logic [1:0] o_reset_ticks;
   logic [3:0] o_capture_data, o_tick_request;
   logic [4:0] o_tick_events;
   logic [31:0] q;
   int failures = 0;
   int n_checks = 0;
   int n;

   always #10 i_clk = ~i_clk;

   clock_select_time_base clock_select_time_base_inst (.i_clk, .i_nrst, .i_xtal_clk,
      .i_rc_clk, .i_test_fast_clk_out, .i_avs_address, .i_avs_read, .i_avs_write,
      .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_sys_clk,
      .o_rc_osc_enable, .o_xtal_osc_enable, .o_logic_supply_raise, .o_wdt_tick,
      .o_buzzer_ticks, .o_port_sample_clk, .o_reset_ticks, .o_capture_data, .o_tick_events,
      .o_tick_request, .o_decade_tick_request);

   osc_model #(.XT_HALF(XT_HALF), .RC_HALF(RC_HALF)) osc_model_inst (.i_clk,
      .i_rc_enable(o_rc_osc_enable), .o_xtal(i_xtal_clk), .o_rc(i_rc_clk));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // One bus transfer, held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd);
      @(posedge i_clk);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_write <= wr;
      i_avs_read <= ~wr;
      @(posedge i_clk);
      while (o_avs_waitrequest !== 1'b0) begin
         @(posedge i_clk);
      end
      rd = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Counts system clock rises over 60 cycles
   task automatic rises(output int cnt);
      logic p;
      cnt = 0;
      p = o_sys_clk;
      repeat (60) begin
         @(negedge i_clk);
         if (o_sys_clk === 1'b1 && p === 1'b0) cnt++;
         p = o_sys_clk;
      end
   endtask

   task automatic print_verdict;
      if (failures == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge i_clk);
      i_nrst <= 1'b1;
      bus(0, ADDR_CLOCK_SOURCE_SELECT, 0, q);
      chk("select reset", 0, q);
      bus(0, ADDR_TIME_BASE_READOUT, 0, q);
      chk("readout reset", 0, q);
      chk("osc enables", 2'b01, {o_rc_osc_enable, o_xtal_osc_enable});
      bus(1, ADDR_CLOCK_SOURCE_SELECT, 1, q);
      @(negedge i_clk);
      chk("rc picked", 3'b111, {o_logic_supply_raise, o_rc_osc_enable, o_xtal_osc_enable});
      repeat (40) @(posedge i_clk);
      bus(0, ADDR_CLOCK_SOURCE_SELECT, 0, q);
      chk("select engaged", 32'h3, q);
      rises(n);
      chk("rc rate", 1, 32'(n >= 60 / (2 * RC_HALF) - 1 && n <= 60 / (2 * RC_HALF) + 1));
      bus(1, ADDR_CLOCK_SOURCE_SELECT, 0, q);
      @(negedge i_clk);
      chk("xtal picked", 0, o_logic_supply_raise);
      repeat (40) @(posedge i_clk);
      chk("rc stopped", 0, o_rc_osc_enable);
      rises(n);
      chk("xtal rate", 1, 32'(n >= 60 / (2 * XT_HALF) - 1 && n <= 60 / (2 * XT_HALF) + 1));
      i_avs_byteenable <= 4'he;
      bus(1, ADDR_CLOCK_SOURCE_SELECT, 1, q);
      i_avs_byteenable <= 4'hf;
      bus(1, 8'h80, 32'hf, q);
      bus(0, 8'h80, 0, q);
      chk("unmapped", 0, q);
      bus(0, ADDR_CLOCK_SOURCE_SELECT, 0, q);
      chk("select kept", 0, q);
      i_test_fast_clk_out <= 1'b1;
      @(negedge i_clk);
      chk("test rc", 1, o_rc_osc_enable);
      @(posedge i_clk);
      i_test_fast_clk_out <= 1'b0;
      // Wait for the 1 Hz stage to go high
      n = 0;
      while (o_reset_ticks[1] !== 1'b1 && n < 80000) begin
         @(negedge i_clk);
         n++;
      end
      chk("1hz reached", 1, o_reset_ticks[1]);
      chk("taps", 8'h80, {o_buzzer_ticks, o_capture_data, o_port_sample_clk});
      bus(0, ADDR_TIME_BASE_READOUT, 0, q);
      chk("readout 1hz", 32'h8, q);
      bus(0, ADDR_TICK_REQUEST, 0, q);
      chk("requests", 32'h7, q);
      bus(0, ADDR_DECADE_TICK_REQUEST, 0, q);
      chk("decade request", 0, q);
      chk("decade pin", 0, o_decade_tick_request);
      bus(1, ADDR_TIME_BASE_READOUT, 32'h5, q);
      @(negedge i_clk);
      chk("reset taps", 0, o_reset_ticks);
      bus(0, ADDR_TIME_BASE_READOUT, 0, q);
      chk("readout cleared", 0, q);
      bus(0, ADDR_TICK_REQUEST, 0, q);
      chk("1hz request", 32'hf, q);
      bus(1, ADDR_TICK_REQUEST, 0, q);
      bus(0, ADDR_TICK_REQUEST, 0, q);
      chk("1hz cleared", 0, q[3]);
      print_verdict();
   end

   // Watchdog
   initial begin
      #1900000;
      failures++;
      print_verdict();
   end
endmodule // clock_select_time_base_tb

// [test/osc_model.sv]
// Purpose: Oscillator levels as the on-chip sources present them
// Assumes: Half periods are counted in i_clk cycles
// Notes: A stopped RC source rests high, as its input is pulled up
`timescale 1ns/1ns
module osc_model #(
   parameter int XT_HALF = 2,
   parameter int RC_HALF = 3
) (
   // Clock
   input wire logic i_clk,
   // Control
   input wire logic i_rc_enable,
   // Levels
   output logic o_xtal = 1'b1,
   output logic o_rc = 1'b1
);
   int xt_cnt = 0;
   int rc_cnt = 0;

   // Crystal never stops
   always @(posedge i_clk) begin
      xt_cnt <= (xt_cnt == XT_HALF - 1) ? 0 : xt_cnt + 1;
      if (xt_cnt == XT_HALF - 1) begin
         o_xtal <= ~o_xtal;
      end
   end

   // RC runs only while enabled, else rests at the pull-up level
   always @(posedge i_clk) begin
      if (!i_rc_enable) begin
         rc_cnt <= 0;
         o_rc <= 1'b1;
      end else begin
         rc_cnt <= (rc_cnt == RC_HALF - 1) ? 0 : rc_cnt + 1;
         if (rc_cnt == RC_HALF - 1) begin
            o_rc <= ~o_rc;
         end
      end
   end
endmodule // osc_model
